// *** rtl/tmr2_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module tmr2_ctrl
    import tmr2_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rstn,
    // Register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // External pins
    input  wire logic       external_count_pin,
    input  wire logic       trigger_pin,
    // Serial port and interrupt system
    input  wire logic       timer1_overflow,
    input  wire logic [1:0] serial_mode,
    input  wire logic       timer_irq_enable,
    output logic            timer_irq,
    output logic            overflow_pulse,
    output logic            uart_rx_clk,
    output logic            uart_tx_clk
);

    // ------------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------------
    logic [1:0] rst_sync_q;
    logic       rst_n;

    // Assertion of reset is immediate, release is clocked through two flops.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // ------------------------------------------------------------------------
    // Pin edge detectors
    // ------------------------------------------------------------------------
    tmr2_edge_if cnt_if ();
    tmr2_edge_if trg_if ();

    assign cnt_if.pin = external_count_pin;
    assign trg_if.pin = trigger_pin;

    tmr2_edge u_cnt_edge (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .edge_if (cnt_if)
    );

    tmr2_edge u_trg_edge (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .edge_if (trg_if)
    );

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    logic [7:0]  ctl_q;
    logic [7:0]  ctl_d;
    logic        speed_q;
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic [15:0] cap_q;
    logic [15:0] cap_d;
    logic [3:0]  pre_q;
    logic [3:0]  div_q;
    logic        rx_clk_q;
    logic        tx_clk_q;
    logic        ovf_pulse_q;
    logic [7:0]  rdata_q;

    // ------------------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------------------
    wire wr_ctl    = reg_wr && (reg_addr == ADDR_CONTROL);
    wire wr_ckc    = reg_wr && (reg_addr == ADDR_CLOCK_CONTROL);
    wire wr_cap_lo = reg_wr && (reg_addr == ADDR_CAP_LOW);
    wire wr_cap_hi = reg_wr && (reg_addr == ADDR_CAP_HIGH);
    wire wr_cnt_lo = reg_wr && (reg_addr == ADDR_CNT_LOW);
    wire wr_cnt_hi = reg_wr && (reg_addr == ADDR_CNT_HIGH);
    wire wr_cnt    = wr_cnt_lo || wr_cnt_hi;
    wire wr_cap    = wr_cap_lo || wr_cap_hi;

    // Control fields.
    wire ovf_flag  = ctl_q[BIT_OVF_FLAG];
    wire ext_flag  = ctl_q[BIT_EXT_FLAG];
    wire rx_sel    = ctl_q[BIT_RX_SEL];
    wire tx_sel    = ctl_q[BIT_TX_SEL];
    wire ext_en    = ctl_q[BIT_EXT_EN];
    wire run       = ctl_q[BIT_RUN];
    wire cnt_src   = ctl_q[BIT_CNT_SRC];
    wire cap_sel   = ctl_q[BIT_CAP_SEL];
    wire baud_mode = rx_sel || tx_sel;

    // ------------------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------------------
    // Baud operation overrides the speed select, which would otherwise pick
    // four or twelve clocks per increment.
    wire [3:0] pre_last = baud_mode ? PRE_LAST_BAUD :
                          (speed_q ? PRE_LAST_FAST : PRE_LAST_SLOW);
    // A compare of at least the terminal keeps a mode change from overrunning.
    wire       pre_tick = (pre_q >= pre_last);

    // The prescaler runs freely so a restart does not shift the count phase.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pre_q <= PRE_RESET;
        end else begin
            pre_q <= pre_tick ? PRE_RESET : pre_q + PRE_ONE;
        end
    end

    // ------------------------------------------------------------------------
    // Count events, overflow and trigger
    // ------------------------------------------------------------------------
    wire count_pulse = cnt_src ? cnt_if.fall : pre_tick;
    wire inc         = run && count_pulse;
    wire ovf_evt     = inc && (cnt_q == COUNT_MAX);
    wire ovf_reload  = ovf_evt && (baud_mode || !cap_sel);
    wire ext_evt     = trg_if.fall && ext_en && !baud_mode;
    wire ext_capture = ext_evt && cap_sel;
    wire ext_reload  = ext_evt && !cap_sel;
    wire ovf_set     = ovf_evt && !baud_mode;

    // ------------------------------------------------------------------------
    // Control register next value
    // ------------------------------------------------------------------------
    // Hardware sets win over a software clear in the same cycle; a written
    // one simply sets the flag, which is how software forces an interrupt.
    always_comb begin
        ctl_d = wr_ctl ? reg_wdata : ctl_q;
        ctl_d[BIT_OVF_FLAG] = ovf_set ||
            (wr_ctl ? reg_wdata[BIT_OVF_FLAG] : ovf_flag);
        ctl_d[BIT_EXT_FLAG] = ext_evt ||
            (wr_ctl ? reg_wdata[BIT_EXT_FLAG] : ext_flag);
    end

    // ------------------------------------------------------------------------
    // Counter and capture pair next values
    // ------------------------------------------------------------------------
    // A software write to a counter byte beats a hardware reload or count in
    // the same cycle, so a preset value is never lost.
    always_comb begin
        cnt_d = cnt_q;
        if (ovf_reload || ext_reload) begin
            cnt_d = cap_q;
        end else if (inc) begin
            cnt_d = cnt_q + COUNT_ONE;
        end
        if (wr_cnt_lo) begin
            cnt_d[7:0] = reg_wdata;
        end
        if (wr_cnt_hi) begin
            cnt_d[15:8] = reg_wdata;
        end
    end

    always_comb begin
        cap_d = cap_q;
        if (ext_capture) begin
            cap_d = cnt_q;
        end
        if (wr_cap_lo) begin
            cap_d[7:0] = reg_wdata;
        end
        if (wr_cap_hi) begin
            cap_d[15:8] = reg_wdata;
        end
    end

    // Register file storage.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctl_q   <= CONTROL_RESET;
            speed_q <= 1'b0;
            cnt_q   <= COUNT_RESET;
            cap_q   <= COUNT_RESET;
        end else begin
            ctl_q   <= ctl_d;
            speed_q <= wr_ckc ? reg_wdata[BIT_SPEED_SEL] : speed_q;
            cnt_q   <= cnt_d;
            cap_q   <= cap_d;
        end
    end

    // ------------------------------------------------------------------------
    // Baud divider and serial clocks
    // ------------------------------------------------------------------------
    wire uart_13   = (serial_mode == UART_MODE1) || (serial_mode == UART_MODE3);
    wire baud_tick = ovf_evt && baud_mode && (div_q == DIV16_LAST);
    wire rx_src    = (rx_sel && uart_13) ? baud_tick : timer1_overflow;
    wire tx_src    = (tx_sel && uart_13) ? baud_tick : timer1_overflow;

    // The divider only advances on baud overflows; it is not cleared on mode
    // entry, so the first serial clock may come early by up to fifteen wraps.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            div_q       <= DIV16_RESET;
            rx_clk_q    <= 1'b0;
            tx_clk_q    <= 1'b0;
            ovf_pulse_q <= 1'b0;
        end else begin
            div_q       <= (ovf_evt && baud_mode) ? div_q + DIV16_ONE : div_q;
            rx_clk_q    <= rx_src;
            tx_clk_q    <= tx_src;
            ovf_pulse_q <= ovf_evt;
        end
    end

    // ------------------------------------------------------------------------
    // Read port and outputs
    // ------------------------------------------------------------------------
    wire [7:0] rd_mux =
        (reg_addr == ADDR_CONTROL)       ? ctl_q :
        (reg_addr == ADDR_CLOCK_CONTROL) ? ({7'h00, speed_q} << BIT_SPEED_SEL) :
        (reg_addr == ADDR_CAP_LOW)       ? cap_q[7:0] :
        (reg_addr == ADDR_CAP_HIGH)      ? cap_q[15:8] :
        (reg_addr == ADDR_CNT_LOW)       ? cnt_q[7:0] :
        (reg_addr == ADDR_CNT_HIGH)      ? cnt_q[15:8] : BYTE_ZERO;

    // Read data stands only in the cycle after the strobe, zero otherwise.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= BYTE_ZERO;
        end else begin
            rdata_q <= reg_rd ? rd_mux : BYTE_ZERO;
        end
    end

    assign reg_rdata      = rdata_q;
    assign timer_irq      = timer_irq_enable && (ovf_flag || ext_flag);
    assign overflow_pulse = ovf_pulse_q;
    assign uart_rx_clk    = rx_clk_q;
    assign uart_tx_clk    = tx_clk_q;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    property p_ovf_set;
        ovf_evt && !baud_mode |=> ovf_flag;
    endproperty
    a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set");

    property p_no_ovf_baud;
        baud_mode && !ovf_flag && !(wr_ctl && reg_wdata[BIT_OVF_FLAG]) |=> !ovf_flag;
    endproperty
    a_no_ovf_baud: assert property (p_no_ovf_baud) else $error("flag set in baud");

    property p_sw_ovf;
        wr_ctl && reg_wdata[BIT_OVF_FLAG] ##1 timer_irq_enable |-> ovf_flag && timer_irq;
    endproperty
    a_sw_ovf: assert property (p_sw_ovf) else $error("forced overflow lost");

    property p_ext_set;
        trg_if.fall && ext_en && !baud_mode |=> ext_flag;
    endproperty
    a_ext_set: assert property (p_ext_set) else $error("external flag not set");

    property p_ext_irq;
        ext_evt && timer_irq_enable ##1 timer_irq_enable |-> timer_irq;
    endproperty
    a_ext_irq: assert property (p_ext_irq) else $error("external irq missing");

    property p_sw_ext;
        wr_ctl && reg_wdata[BIT_EXT_FLAG] |=> ext_flag;
    endproperty
    a_sw_ext: assert property (p_sw_ext) else $error("forced external lost");

    property p_rx_t1;
        !rx_sel && timer1_overflow |=> uart_rx_clk;
    endproperty
    a_rx_t1: assert property (p_rx_t1) else $error("rx clock not timer one");

    property p_tx_baud;
        ovf_evt && tx_sel && uart_13 && (div_q == DIV16_LAST) |=> uart_tx_clk;
    endproperty
    a_tx_baud: assert property (p_tx_baud) else $error("tx baud clock missing");

    property p_ext_off;
        !ext_en && !ext_flag && !(wr_ctl && reg_wdata[BIT_EXT_FLAG]) |=> !ext_flag;
    endproperty
    a_ext_off: assert property (p_ext_off) else $error("trigger not ignored");

    property p_hold;
        !run && !wr_cnt && !ext_reload |=> $stable(cnt_q);
    endproperty
    a_hold: assert property (p_hold) else $error("stopped counter moved");

    property p_fast;
        pre_tick && !baud_mode && speed_q ##1 (!baud_mode && speed_q)[*3] |=> pre_tick;
    endproperty
    a_fast: assert property (p_fast) else $error("divide by four wrong");

    property p_slow;
        pre_tick && !baud_mode && !speed_q ##1 (!baud_mode && !speed_q)[*8]
            ##1 (!baud_mode && !speed_q)[*3] |=> pre_tick;
    endproperty
    a_slow: assert property (p_slow) else $error("divide by twelve wrong");

    property p_baud_rate;
        pre_tick && baud_mode ##1 baud_mode |=> pre_tick;
    endproperty
    a_baud_rate: assert property (p_baud_rate) else $error("divide by two wrong");

    property p_ext_count;
        cnt_src && run && cnt_if.fall && !wr_cnt && !ovf_evt && !ext_reload
            |=> cnt_q == $past(cnt_q) + COUNT_ONE;
    endproperty
    a_ext_count: assert property (p_ext_count) else $error("pin edge not counted");

    property p_capture;
        ext_evt && cap_sel && !wr_cap |=> cap_q == $past(cnt_q);
    endproperty
    a_capture: assert property (p_capture) else $error("capture wrong");

    property p_reload;
        ovf_evt && (baud_mode || !cap_sel) && !wr_cnt |=> cnt_q == $past(cap_q);
    endproperty
    a_reload: assert property (p_reload) else $error("reload wrong");

    property p_div16;
        uart_tx_clk && $past(tx_sel) && $past(uart_13) |-> !$past(tx_clk_q) && $past(div_q) == DIV16_LAST;
    endproperty
    a_div16: assert property (p_div16) else $error("baud clock too dense");

    property p_one_edge;
        cnt_if.fall |-> !$past(external_count_pin, 2) && $past(external_count_pin, 3) ##1 !cnt_if.fall;
    endproperty
    a_one_edge: assert property (p_one_edge) else $error("double edge event");

    c_capture: cover property (ext_capture);
    c_ext_reload: cover property (ext_reload);
    c_ovf_reload: cover property (ovf_reload && !baud_mode);
    c_baud_tick: cover property (baud_tick);

endmodule : tmr2_ctrl
`default_nettype wire

// *** common/tmr2_pkg.sv ***
// ----------------------------------------------------------------------------
// Timer two control package
// ----------------------------------------------------------------------------
package tmr2_pkg;

    // ------------------------------------------------------------------------
    // Register addresses on the plain register port
    // ------------------------------------------------------------------------
    localparam logic [7:0] ADDR_CLOCK_CONTROL = 8'h8E;
    localparam logic [7:0] ADDR_CONTROL       = 8'hC8;
    localparam logic [7:0] ADDR_CAP_LOW       = 8'hCA;
    localparam logic [7:0] ADDR_CAP_HIGH      = 8'hCB;
    localparam logic [7:0] ADDR_CNT_LOW       = 8'hCC;
    localparam logic [7:0] ADDR_CNT_HIGH      = 8'hCD;

    // ------------------------------------------------------------------------
    // Field positions of the control register
    // ------------------------------------------------------------------------
    localparam int BIT_OVF_FLAG   = 7;
    localparam int BIT_EXT_FLAG   = 6;
    localparam int BIT_RX_SEL     = 5;
    localparam int BIT_TX_SEL     = 4;
    localparam int BIT_EXT_EN     = 3;
    localparam int BIT_RUN        = 2;
    localparam int BIT_CNT_SRC    = 1;
    localparam int BIT_CAP_SEL    = 0;
    // Clock-speed select sits in the clock control register.
    localparam int BIT_SPEED_SEL  = 5;

    // ------------------------------------------------------------------------
    // Reset values and counter limits
    // ------------------------------------------------------------------------
    localparam logic [7:0]  CONTROL_RESET = 8'h00;
    localparam logic [15:0] COUNT_RESET   = 16'h0000;
    localparam logic [15:0] COUNT_MAX     = 16'hFFFF;
    localparam logic [15:0] COUNT_ONE     = 16'h0001;
    localparam logic [7:0]  BYTE_ZERO     = 8'h00;

    // ------------------------------------------------------------------------
    // Prescaler terminal counts: divide by two, four and twelve
    // ------------------------------------------------------------------------
    localparam logic [3:0] PRE_RESET     = 4'h0;
    localparam logic [3:0] PRE_ONE       = 4'h1;
    localparam logic [3:0] PRE_LAST_BAUD = 4'h1;
    localparam logic [3:0] PRE_LAST_FAST = 4'h3;
    localparam logic [3:0] PRE_LAST_SLOW = 4'hB;

    // ------------------------------------------------------------------------
    // Baud divider and serial modes
    // ------------------------------------------------------------------------
    localparam logic [3:0] DIV16_RESET = 4'h0;
    localparam logic [3:0] DIV16_ONE   = 4'h1;
    localparam logic [3:0] DIV16_LAST  = 4'hF;
    localparam logic [1:0] UART_MODE1  = 2'h1;
    localparam logic [1:0] UART_MODE3  = 2'h3;

endpackage : tmr2_pkg

// *** common/tmr2_edge_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// Carrier between a pin and its falling-edge detector
// ----------------------------------------------------------------------------
interface tmr2_edge_if;
    logic pin;   // Raw level from outside the clock domain.
    logic fall;  // One-cycle pulse per falling edge.

    modport det (input pin, output fall);
    modport user (output pin, input fall);
endinterface : tmr2_edge_if
`default_nettype wire

// *** rtl/tmr2_edge.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// Pin synchroniser with falling-edge detector
// ----------------------------------------------------------------------------
module tmr2_edge (
    // Clock and reset
    input wire logic   clk_sys,
    input wire logic   rst_n,
    // Pin and event
    tmr2_edge_if.det   edge_if
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    // Two flops bring the pin in; a third holds the previous clean sample.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
            prev_q <= 1'b1;
        end else begin
            meta_q <= edge_if.pin;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // Only clean samples are compared, so each edge gives one pulse.
    assign edge_if.fall = prev_q & ~sync_q;

endmodule : tmr2_edge
`default_nettype wire

// *** test/tmr2_pins_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Pin-side partner: count pin, trigger pin and timer one overflow
// ---------------------------------------------------------------
module tmr2_pins_model (
    // Clock
    input  wire logic clk_sys,
    // Lines toward the timer
    output logic      external_count_pin,
    output logic      trigger_pin,
    output logic      timer1_overflow
);
    // Pins rest high as with a pull-up, so reset never sees a false edge.
    initial begin
        external_count_pin = 1'b1;
        trigger_pin        = 1'b1;
        timer1_overflow    = 1'b0;
    end

    // Each level is held three clocks, beyond the two the synchroniser needs.
    task automatic fall_count(input int n);
        repeat (n) begin
            @(posedge clk_sys) external_count_pin <= 1'b0;
            repeat (3) @(posedge clk_sys);
            external_count_pin <= 1'b1;
            repeat (3) @(posedge clk_sys);
        end
    endtask : fall_count

    // One falling edge on the trigger line.
    task automatic fall_trig();
        @(posedge clk_sys) trigger_pin <= 1'b0;
        repeat (3) @(posedge clk_sys);
        trigger_pin <= 1'b1;
        repeat (3) @(posedge clk_sys);
    endtask : fall_trig

    // A single-cycle overflow pulse from the other timer.
    task automatic t1_pulse();
        @(posedge clk_sys) timer1_overflow <= 1'b1;
        @(posedge clk_sys) timer1_overflow <= 1'b0;
    endtask : t1_pulse
endmodule : tmr2_pins_model
`default_nettype wire

// *** test/timer2_control_capture_reload_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Self-checking bench for the timer two control block
// ---------------------------------------------------------------
module timer2_control_capture_reload_tb_top
    import tmr2_pkg::*;
;
    logic        clk_sys, rstn, reg_wr, reg_rd, timer_irq_enable;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, r, d;
    logic [1:0]  serial_mode;
    logic [15:0] n_tx, n_rx;
    wire logic   cnt_pin, trig_pin, t1_ovf;
    logic        timer_irq, overflow_pulse, uart_rx_clk, uart_tx_clk;
    int          fail_count, n_compared, cyc;
    logic [7:0]  am [7] = '{ADDR_CLOCK_CONTROL, ADDR_CONTROL, ADDR_CAP_LOW,
                            ADDR_CAP_HIGH, ADDR_CNT_LOW, ADDR_CNT_HIGH, 8'hC9};

    tmr2_pins_model pm (.clk_sys(clk_sys), .external_count_pin(cnt_pin),
        .trigger_pin(trig_pin), .timer1_overflow(t1_ovf));
    tmr2_ctrl dut (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .external_count_pin(cnt_pin), .trigger_pin(trig_pin), .timer1_overflow(t1_ovf),
        .serial_mode(serial_mode), .timer_irq_enable(timer_irq_enable),
        .timer_irq(timer_irq), .overflow_pulse(overflow_pulse),
        .uart_rx_clk(uart_rx_clk), .uart_tx_clk(uart_tx_clk));

    // Free-running 25 MHz clock.
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    // A hang is cut short at 10000 cycles, well beyond the thousand or so cycles the run needs.
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            fail_count++;
            final_report();
        end
    end

    task automatic final_report();
        if (fail_count == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    // Range check, used where the free-running prescaler phase is unknown.
    task automatic rng(input logic [15:0] g, input logic [15:0] lo, input logic [15:0] hi);
        n_compared++;
        if ((g >= lo && g <= hi) !== 1'b1) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, g, lo, hi);
        end
    endtask : rng

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe, so sample mid-cycle.
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        v = reg_rdata;
    endtask : rd

    task automatic irq(input logic e);
        @(negedge clk_sys);
        chk({15'h0, timer_irq}, {15'h0, e});
    endtask : irq

    task automatic wait_ovf();
        int i;
        i = 0;
        while (overflow_pulse !== 1'b1 && i < 200) begin
            @(negedge clk_sys);
            i++;
        end
        chk({15'h0, overflow_pulse}, 16'h1);
    endtask : wait_ovf

    task automatic t_regs();
        wr(8'hC9, 8'hFF);
        foreach (am[i]) begin
            rd(am[i], r);
            chk(r, 8'h00);
        end
        wr(ADDR_CLOCK_CONTROL, 8'hFF);
        rd(ADDR_CLOCK_CONTROL, r);
        chk(r, 8'h20);
    endtask : t_regs

    task automatic t_ovf();
        wr(ADDR_CNT_LOW, 8'hFE);
        wr(ADDR_CNT_HIGH, 8'hFF);
        wr(ADDR_CONTROL, 8'h05);
        wait_ovf();
        rd(ADDR_CONTROL, r);
        chk(r, 8'h85);
        irq(1'b1);
        wr(ADDR_CONTROL, 8'h01);
        rd(ADDR_CNT_LOW, d);
        repeat (20) @(posedge clk_sys);
        rd(ADDR_CNT_LOW, r);
        chk(r, d);
        irq(1'b0);
        wr(ADDR_CONTROL, 8'h81);
        irq(1'b1);
        wr(ADDR_CONTROL, 8'h41);
        irq(1'b1);
        @(posedge clk_sys) timer_irq_enable <= 1'b0;
        irq(1'b0);
        @(posedge clk_sys) timer_irq_enable <= 1'b1;
        wr(ADDR_CONTROL, 8'h00);
    endtask : t_ovf

    task automatic t_rate(input logic [7:0] sp, input logic [15:0] lo, input logic [15:0] hi);
        wr(ADDR_CNT_LOW, 8'h00);
        wr(ADDR_CNT_HIGH, 8'h00);
        wr(ADDR_CLOCK_CONTROL, sp);
        wr(ADDR_CONTROL, 8'h04);
        repeat (120) @(posedge clk_sys);
        wr(ADDR_CONTROL, 8'h00);
        rd(ADDR_CNT_LOW, r);
        rng(r, lo, hi);
    endtask : t_rate

    task automatic t_pin();
        wr(ADDR_CNT_LOW, 8'h00);
        wr(ADDR_CONTROL, 8'h06);
        pm.fall_count(3);
        repeat (4) @(posedge clk_sys);
        wr(ADDR_CONTROL, 8'h02);
        rd(ADDR_CNT_LOW, r);
        chk(r, 8'h03);
        pm.fall_count(2);
        rd(ADDR_CNT_LOW, r);
        chk(r, 8'h03);
    endtask : t_pin

    task automatic t_trig();
        wr(ADDR_CNT_LOW, 8'h34);
        wr(ADDR_CNT_HIGH, 8'h12);
        wr(ADDR_CONTROL, 8'h09);
        pm.fall_trig();
        rd(ADDR_CAP_LOW, r);
        chk(r, 8'h34);
        rd(ADDR_CAP_HIGH, r);
        chk(r, 8'h12);
        rd(ADDR_CONTROL, r);
        chk(r, 8'h49);
        irq(1'b1);
        wr(ADDR_CONTROL, 8'h01);
        wr(ADDR_CNT_LOW, 8'h55);
        pm.fall_trig();
        rd(ADDR_CAP_LOW, r);
        chk(r, 8'h34);
        rd(ADDR_CONTROL, r);
        chk(r, 8'h01);
        wr(ADDR_CAP_LOW, 8'hCD);
        wr(ADDR_CAP_HIGH, 8'hAB);
        wr(ADDR_CONTROL, 8'h08);
        pm.fall_trig();
        rd(ADDR_CNT_LOW, r);
        chk(r, 8'hCD);
        wr(ADDR_CNT_LOW, 8'hFF);
        wr(ADDR_CNT_HIGH, 8'hFF);
        wr(ADDR_CLOCK_CONTROL, 8'h20);
        wr(ADDR_CONTROL, 8'h04);
        wait_ovf();
        wr(ADDR_CONTROL, 8'h00);
        rd(ADDR_CNT_HIGH, r);
        chk(r, 8'hAB);
    endtask : t_trig

    // All-ones reload makes every increment an overflow: 160 wraps give ten clocks.
    task automatic t_baud();
        wr(ADDR_CAP_LOW, 8'hFF);
        wr(ADDR_CAP_HIGH, 8'hFF);
        wr(ADDR_CNT_LOW, 8'hFF);
        wr(ADDR_CNT_HIGH, 8'hFF);
        wr(ADDR_CONTROL, 8'h3D);
        n_tx = 16'h0;
        n_rx = 16'h0;
        repeat (320) begin
            @(negedge clk_sys);
            n_tx += {15'h0, uart_tx_clk};
            n_rx += {15'h0, uart_rx_clk};
        end
        rng(n_tx, 16'd9, 16'd11);
        rng(n_rx, 16'd9, 16'd11);
        rd(ADDR_CONTROL, r);
        chk(r, 8'h3D);
        pm.fall_trig();
        rd(ADDR_CONTROL, r);
        chk(r, 8'h3D);
        wr(ADDR_CONTROL, 8'h10);
        n_rx = 16'h0;
        fork
            pm.t1_pulse();
            repeat (4) begin
                @(negedge clk_sys);
                n_rx += {15'h0, uart_rx_clk};
            end
        join
        chk(n_rx, 16'h1);
        @(posedge clk_sys) serial_mode <= 2'h0;
        n_tx = 16'h0;
        fork
            pm.t1_pulse();
            repeat (4) begin
                @(negedge clk_sys);
                n_tx += {15'h0, uart_tx_clk};
            end
        join
        chk(n_tx, 16'h1);
        wr(ADDR_CONTROL, 8'h00);
    endtask : t_baud

    // Reset is held six cycles, then released through the internal flops.
    initial begin
        rstn             = 1'b0;
        reg_wr           = 1'b0;
        reg_rd           = 1'b0;
        reg_addr         = 8'h00;
        reg_wdata        = 8'h00;
        serial_mode      = UART_MODE1;
        timer_irq_enable = 1'b1;
        repeat (6) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        t_regs();
        t_ovf();
        t_rate(8'h20, 16'd29, 16'd32);
        t_rate(8'h00, 16'd9, 16'd11);
        t_pin();
        t_trig();
        t_baud();
        final_report();
    end
endmodule : timer2_control_capture_reload_tb_top
`default_nettype wire
